// file: verilog/qcadc_pkg.sv
// Constants, types and helpers shared by the quad current converter control
package qcadc_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned PRESCALE_DIV = 4;
  localparam logic [1:0] PRESCALE_LAST = 2'(PRESCALE_DIV - 1);
  // Sequencer figures, in internal clock ticks
  localparam logic [11:0] CONT_MRAZ_TICKS = 12'd1470;
  localparam logic [11:0] NCONT_MRAZ_TICKS = 12'd2901;
  localparam logic [11:0] CONT_READY_DELAY = 12'd1380;
  localparam logic [11:0] FIRST_NCONT_READY_DELAY = 12'd1379;
  // Least spacing of toggle edges: 2.5 kSPS and 3.125 kSPS
  localparam int unsigned LOPWR_MIN_PERIOD_NS = 400000;
  localparam int unsigned HISPD_MIN_PERIOD_NS = 320000;
  localparam int unsigned LOPWR_MIN_CYC =
    (LOPWR_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HISPD_MIN_CYC =
    (HISPD_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] SETTLE_INTEGRATE_TOGGLE = 3'd4;

  // ****************************************
  // Register map
  // ****************************************
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] RESULT_OFS = 8'h10;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned ST_STATE_LSB = 0;
  localparam int unsigned ST_CONT_BIT = 4;
  localparam int unsigned ST_MBSY_BIT = 5;
  localparam int unsigned ST_READY_BIT = 6;
  localparam int unsigned ST_SPEED_BIT = 7;
  localparam int unsigned ST_PRESC_BIT = 8;
  localparam int unsigned ST_SETTLED_BIT = 9;
  localparam int unsigned ST_OVERRUN_BIT = 10;
  localparam int unsigned RESULT_W = 20;
  localparam int unsigned CHANNELS = 4;
  localparam int unsigned SHIFT_W = RESULT_W * CHANNELS;

  typedef enum logic [3:0] {
    ST_BOOT, ST_NC_MEAS_A, ST_NC_PREP_A, ST_INT_A, ST_INT_B_MEAS_A,
    ST_INT_A_MEAS_B, ST_INT_B, ST_NC_PREP_B, ST_NC_MEAS_B
  } qcadc_state_t;

  typedef struct packed {
    logic clock_prescale_sel;
    logic speed_power_sel;
    logic integrate_toggle;
    logic serial_shift_clock;
    logic chain_in;
  } qcadc_pins_t;

  typedef struct packed {
    logic [RESULT_W-1:0] integrate_toggle_b;
    logic [RESULT_W-1:0] integrate_toggle_a;
  } qcadc_adc_t;

  typedef struct packed {
    logic integ_side_a;
    logic meas_busy;
    logic cont_mode;
    logic inputs_grounded;
    logic integ_reset;
  } qcadc_seq_t;

  function automatic logic qcadc_is_cont(input qcadc_state_t s);
    return s inside {ST_INT_A, ST_INT_B_MEAS_A, ST_INT_A_MEAS_B, ST_INT_B};
  endfunction

endpackage

// file: verilog/qcadc_ctrl.sv
// Digital control, sequencer and serial readout of the quad converter
//
// Summary of operation
// - Prescale pin high divides system clock by four
// - Speed select low: low power, 2.5 kSPS limit
// - Speed select high: high speed, 3.125 kSPS limit
// - Ready output low when a result is available
// - Ready timed from divided clock, arbitrary phase
// - Low reset clears asynchronously; host holds 50 us, bench holds 20 cycles (500 ns)
// - Toggle input sets integration period, synchronised
// - Readout independent of conversion clock
// - Two converters interleaved over four channels
// - Each cycle converts two sides, then resets them
// - Long conversion gives continuous integration mode
// - Short conversion pauses integration, non-continuous mode
// - Chain input shifts in upstream converter data
// - Ready delays 1380 continuous, 1379 first non-continuous
// - Ready stays low until shift clock high-low
// - Sequencer follows toggle level, not edges
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/10ps
module qcadc_ctrl #(
  parameter int unsigned LOPWR_MIN_CYC = qcadc_pkg::LOPWR_MIN_CYC,
  parameter int unsigned HISPD_MIN_CYC = qcadc_pkg::HISPD_MIN_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [qcadc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire qcadc_pkg::qcadc_pins_t pins,
  input wire qcadc_pkg::qcadc_adc_t adc,
  output logic result_ready_n,
  output logic serial_out,
  output qcadc_pkg::qcadc_seq_t seq
);
  import qcadc_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  qcadc_pins_t pins_meta_reg;
  qcadc_pins_t pins_s_reg;
  logic sclk_d_reg;
  logic tog_d_reg;
  logic [1:0] warm_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_meta_reg <= '0;
      pins_s_reg <= '0;
      sclk_d_reg <= 1'b0;
      tog_d_reg <= 1'b0;
      warm_reg <= 2'h0;
    end else begin
      pins_meta_reg <= pins;
      pins_s_reg <= pins_meta_reg;
      if (warm_reg != 2'h3) warm_reg <= warm_reg + 2'h1;
      sclk_d_reg <= pins_s_reg.serial_shift_clock;
      tog_d_reg <= pins_s_reg.integrate_toggle;
    end
  end

  wire logic tog = pins_s_reg.integrate_toggle;
  // No edges until delayed copies hold real pin levels, else a pin
  // that is high at reset release looks like a fresh edge
  wire logic warm = (warm_reg == 2'h3);
  wire logic sclk_rise = warm & pins_s_reg.serial_shift_clock & ~sclk_d_reg;
  wire logic sclk_fall = warm & ~pins_s_reg.serial_shift_clock & sclk_d_reg;
  wire logic tog_edge = warm & (tog ^ tog_d_reg);

  // ****************************************
  // Internal clock divider
  // ****************************************
  // Free running, so its phase against the toggle is not controlled
  logic [1:0] div_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) div_reg <= 2'h0;
    else div_reg <= div_reg + 2'h1;
  end
  wire logic tick = ~pins_s_reg.clock_prescale_sel |
                    (div_reg == PRESCALE_LAST);

  // ****************************************
  // Integrate/measure sequencer
  // ****************************************
  qcadc_state_t state_reg, state_next;
  logic [11:0] mraz_cnt_reg, mraz_half_reg, rdy_cnt_reg;
  logic mraz_start, rdy_start;
  logic [11:0] mraz_len, rdy_len;
  logic run_en;
  wire logic mbsy = (mraz_cnt_reg != 12'h000);

  always_comb begin
    state_next = state_reg;
    mraz_start = 1'b0;
    mraz_len = CONT_MRAZ_TICKS;
    rdy_start = 1'b0;
    rdy_len = CONT_READY_DELAY;
    if (!run_en) begin
      state_next = ST_BOOT;
    end else if (tick) begin
      unique case (state_reg)
        ST_BOOT: begin
          state_next = tog ? ST_NC_MEAS_A : ST_NC_MEAS_B;
          mraz_start = 1'b1;
          mraz_len = NCONT_MRAZ_TICKS;
        end
        ST_NC_MEAS_A: if (!mbsy) state_next = ST_NC_PREP_A;
        ST_NC_PREP_A: if (tog) state_next = ST_INT_A;
        ST_NC_PREP_B: if (!tog) state_next = ST_INT_B;
        ST_NC_MEAS_B: if (!mbsy) state_next = ST_NC_PREP_B;
        ST_INT_A: if (!tog) begin
          state_next = ST_INT_B_MEAS_A;
          mraz_start = 1'b1;
          rdy_start = 1'b1;
        end
        ST_INT_B: if (tog) begin
          state_next = ST_INT_A_MEAS_B;
          mraz_start = 1'b1;
          rdy_start = 1'b1;
        end
        ST_INT_B_MEAS_A: if (tog) begin
          state_next = mbsy ? ST_NC_MEAS_A : ST_INT_A_MEAS_B;
          mraz_start = 1'b1;
          mraz_len = mbsy ? NCONT_MRAZ_TICKS : CONT_MRAZ_TICKS;
          rdy_start = 1'b1;
          rdy_len = mbsy ? FIRST_NCONT_READY_DELAY
                         : CONT_READY_DELAY;
        end
        ST_INT_A_MEAS_B: if (!tog) begin
          state_next = mbsy ? ST_NC_MEAS_B : ST_INT_B_MEAS_A;
          mraz_start = 1'b1;
          mraz_len = mbsy ? NCONT_MRAZ_TICKS : CONT_MRAZ_TICKS;
          rdy_start = 1'b1;
          rdy_len = mbsy ? FIRST_NCONT_READY_DELAY
                         : CONT_READY_DELAY;
        end
        default: state_next = ST_BOOT;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_BOOT;
      mraz_cnt_reg <= 12'h000;
      mraz_half_reg <= 12'h000;
      rdy_cnt_reg <= 12'h000;
    end else begin
      state_reg <= state_next;
      if (mraz_start) begin
        mraz_cnt_reg <= mraz_len;
        mraz_half_reg <= mraz_len >> 1;
      end else if (tick && mbsy) begin
        mraz_cnt_reg <= mraz_cnt_reg - 12'h001;
      end
      if (!run_en) rdy_cnt_reg <= 12'h000;
      else if (rdy_start) rdy_cnt_reg <= rdy_len;
      else if (tick && rdy_cnt_reg != 12'h000)
        rdy_cnt_reg <= rdy_cnt_reg - 12'h001;
    end
  end

  // Converter A serves channels 1 and 2, converter B channels 3 and 4
  wire logic cap_first = tick && mbsy &&
                         (mraz_cnt_reg == mraz_half_reg);
  wire logic load = tick && (rdy_cnt_reg == 12'h001);
  logic [RESULT_W-1:0] first_a_reg, first_b_reg;
  logic [RESULT_W-1:0] result_reg [CHANNELS];
  wire logic [SHIFT_W-1:0] frame = {first_a_reg, adc.integrate_toggle_a,
                                    first_b_reg, adc.integrate_toggle_b};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_a_reg <= '0;
      first_b_reg <= '0;
      seq <= '0;
      for (int i = 0; i < CHANNELS; i++) result_reg[i] <= '0;
    end else begin
      if (cap_first) begin
        first_a_reg <= adc.integrate_toggle_a;
        first_b_reg <= adc.integrate_toggle_b;
      end
      if (load) begin
        result_reg[0] <= first_a_reg;
        result_reg[1] <= adc.integrate_toggle_a;
        result_reg[2] <= first_b_reg;
        result_reg[3] <= adc.integrate_toggle_b;
      end
      seq.integ_side_a <= state_next inside {ST_INT_A, ST_INT_A_MEAS_B};
      seq.meas_busy <= mbsy;
      seq.cont_mode <= qcadc_is_cont(state_next);
      seq.inputs_grounded <= ~qcadc_is_cont(state_next);
      seq.integ_reset <= tick && (mraz_cnt_reg == 12'h001);
    end
  end

  // ****************************************
  // Serial readout and ready
  // ****************************************
  // Shifts on sampled shift clock rising edges; loads the frame on the tick that ends the ready count
  logic [SHIFT_W-1:0] shift_reg;
  logic [2:0] integrate_toggle_cnt_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_reg <= '0;
      serial_out <= 1'b0;
      result_ready_n <= 1'b1;
      integrate_toggle_cnt_reg <= 3'h0;
    end else begin
      if (load) begin
        shift_reg <= frame;
        serial_out <= frame[SHIFT_W-1];
        result_ready_n <= 1'b0;
        if (integrate_toggle_cnt_reg != SETTLE_INTEGRATE_TOGGLE)
          integrate_toggle_cnt_reg <= integrate_toggle_cnt_reg + 3'h1;
      end else begin
        if (sclk_rise) begin
          shift_reg <= {shift_reg[SHIFT_W-2:0],
                        pins_s_reg.chain_in};
          serial_out <= shift_reg[SHIFT_W-2];
        end
        if (sclk_fall) result_ready_n <= 1'b1;
      end
    end
  end

  // ****************************************
  // Rate check against speed mode
  // ****************************************
  logic [16:0] gap_cnt_reg;
  logic overrun_reg;
  logic [31:0] ctrl_reg;
  wire logic [16:0] min_gap = pins_s_reg.speed_power_sel ?
    17'(HISPD_MIN_CYC) : 17'(LOPWR_MIN_CYC);
  wire logic overrun_set = tog_edge && (gap_cnt_reg < min_gap);
  assign run_en = ctrl_reg[CTRL_RUN_BIT];

  // ****************************************
  // APB slave, one wait state
  // ****************************************
  wire logic acc = psel & penable & ~pready;
  wire logic done = psel & penable & pready;
  wire logic [ADDR_W-1:0] res_idx_a = paddr - RESULT_OFS;
  wire logic is_ctrl = (paddr == CTRL_OFS);
  wire logic is_stat = (paddr == STATUS_OFS);
  wire logic is_res = (paddr >= RESULT_OFS) && (paddr[1:0] == 2'h0) &&
                      (res_idx_a[ADDR_W-1:2] < 6'(CHANNELS));
  wire logic clr_ovr = done && pwrite && is_stat && pwdata[ST_OVERRUN_BIT];
  wire logic [31:0] status = {21'h0, overrun_reg,
    integrate_toggle_cnt_reg == SETTLE_INTEGRATE_TOGGLE, pins_s_reg.clock_prescale_sel,
    pins_s_reg.speed_power_sel, ~result_ready_n, mbsy,
    qcadc_is_cont(state_reg), state_reg};
  wire logic [31:0] rd_mux = is_ctrl ? ctrl_reg : is_stat ? status :
    is_res ? 32'(result_reg[res_idx_a[3:2]]) : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      ctrl_reg <= CTRL_RESET;
      gap_cnt_reg <= 17'h0_0000;
      overrun_reg <= 1'b0;
    end else begin
      pready <= acc;
      pslverr <= acc & ~(is_ctrl | is_stat | is_res);
      prdata <= (acc && !pwrite) ? rd_mux : 32'h0000_0000;
      if (done && pwrite && is_ctrl) ctrl_reg <= pwdata;
      if (tog_edge) gap_cnt_reg <= 17'h0_0000;
      else if (gap_cnt_reg != 17'h1_FFFF)
        gap_cnt_reg <= gap_cnt_reg + 17'h0_0001;
      // Set wins over a same-cycle clear
      if (overrun_set) overrun_reg <= 1'b1;
      else if (clr_ovr) overrun_reg <= 1'b0;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_cont_entry;
    tick && run_en && state_reg == ST_INT_A && !tog;
  endsequence
  sequence s_ready_loaded;
    rdy_cnt_reg == CONT_READY_DELAY;
  endsequence

  property p_div4;
    @(posedge pclk) disable iff (!presetn)
    pins_s_reg.clock_prescale_sel && tick |=> !tick ##1 !tick ##1 !tick;
  endproperty
  a_div4: assert property (p_div4) else $error("prescale tick");

  property p_cont_ready;
    @(posedge pclk) disable iff (!presetn)
    s_cont_entry |=> s_ready_loaded ##0 state_reg == ST_INT_B_MEAS_A;
  endproperty
  a_cont_ready: assert property (p_cont_ready)
    else $error("cont ready delay");

  property p_ncont_entry;
    @(posedge pclk) disable iff (!presetn)
    tick && run_en && state_reg == ST_INT_B_MEAS_A && tog && mbsy |=>
      state_reg == ST_NC_MEAS_A && rdy_cnt_reg == FIRST_NCONT_READY_DELAY;
  endproperty
  a_ncont_entry: assert property (p_ncont_entry)
    else $error("ncont entry");

  property p_ready_low;
    @(posedge pclk) disable iff (!presetn)
    load |=> !result_ready_n;
  endproperty
  a_ready_low: assert property (p_ready_low) else $error("ready");

  property p_ready_hold;
    @(posedge pclk) disable iff (!presetn)
    !result_ready_n && !sclk_fall |=> !result_ready_n;
  endproperty
  a_ready_hold: assert property (p_ready_hold)
    else $error("ready hold");

  property p_ready_release;
    @(posedge pclk) disable iff (!presetn)
    sclk_fall && !load |=> result_ready_n;
  endproperty
  a_ready_release: assert property (p_ready_release)
    else $error("ready release");

  property p_chain;
    @(posedge pclk) disable iff (!presetn)
    sclk_rise && !load |=> shift_reg[0] == $past(pins_s_reg.chain_in);
  endproperty
  a_chain: assert property (p_chain) else $error("chain shift");

  property p_level;
    @(posedge pclk) disable iff (!presetn)
    tick && run_en && state_reg == ST_INT_B && tog |=>
      state_reg == ST_INT_A_MEAS_B && mraz_cnt_reg == CONT_MRAZ_TICKS;
  endproperty
  a_level: assert property (p_level) else $error("level step");

  property p_boot;
    @(posedge pclk) disable iff (!presetn)
    state_reg == ST_BOOT |-> result_ready_n || $past(load);
  endproperty
  a_boot: assert property (p_boot) else $error("boot ready");

  property p_rate;
    @(posedge pclk) disable iff (!presetn)
    overrun_set |=> overrun_reg;
  endproperty
  a_rate: assert property (p_rate) else $error("rate flag");

endmodule

// file: verif/qcadc_host_model.sv
// Host model: drives the converter pins and unloads serial frames
`timescale 1ns/10ps
module qcadc_host_model (
  input wire logic pclk,
  input wire logic result_ready_n,
  input wire logic serial_out,
  output qcadc_pkg::qcadc_pins_t pins
);
  import qcadc_pkg::*;
  // ********
  // Pin drive and frame unload
  // ********
  localparam logic [3:0] CHAIN = 4'hA;
  logic [83:0] frame_reg = '0;
  logic [1:0] rdy_seen = '0;
  logic busy = 1'b0;
  int cyc = 0;
  int tog_cyc = 0;
  int fall_cyc = 0;
  int frame_cnt = 0;

  initial pins = '0;
  always @(posedge pclk) cyc <= cyc + 1;

  // Never toggles mid-frame, so shift clock sits low around it
  task automatic flip();
    while (busy)
      @(posedge pclk);
    pins.integrate_toggle <= ~pins.integrate_toggle;
    tog_cyc = cyc;
  endtask

  task automatic cfg(input logic presc, input logic spd);
    pins.clock_prescale_sel <= presc;
    pins.speed_power_sel <= spd;
  endtask

  // Ready is polled, not timed from the toggle
  initial forever begin
    @(posedge pclk);
    if (result_ready_n !== 1'b0) begin
      pins.chain_in <= ~pins.chain_in;
    end else begin
      busy = 1'b1;
      fall_cyc = cyc;
      for (int i = 0; i < 84; i++) begin
        frame_reg = {frame_reg[82:0], serial_out};
        pins.chain_in <= (i < 4) ? CHAIN[3 - i] : 1'b0;
        @(posedge pclk);
        if (i < 2)
          rdy_seen[1 - i] = result_ready_n;
        pins.serial_shift_clock <= 1'b1;
        repeat (4) @(posedge pclk);
        pins.serial_shift_clock <= 1'b0;
        repeat (4) @(posedge pclk);
      end
      frame_cnt++;
      busy = 1'b0;
    end
  end
endmodule

// file: verif/qcadc_ctrl_bench.sv
// Self-checking bench for the quad converter control block
`timescale 1ns/10ps
module qcadc_ctrl_bench;
  import qcadc_pkg::*;
  // ********
  // Signals and instances
  // ********
  localparam int LOW_CYC = 40;
  localparam int HIGH_CYC = 32;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic result_ready_n, serial_out, rd_err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [19:0] code_a, code_b;
  qcadc_pins_t pins;
  qcadc_adc_t adc;
  qcadc_seq_t seq;
  int errors = 0;
  int total_checks = 0;
  int base = 0;

  qcadc_ctrl #(.LOPWR_MIN_CYC(LOW_CYC), .HISPD_MIN_CYC(HIGH_CYC)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins), .adc(adc),
    .result_ready_n(result_ready_n), .serial_out(serial_out), .seq(seq)
  );
  qcadc_host_model HOST (
    .pclk(pclk), .result_ready_n(result_ready_n),
    .serial_out(serial_out), .pins(pins)
  );

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // ********
  // Helpers
  // ********
  task automatic check_val(input logic [83:0] got, input logic [83:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_win(input int got, input int lo, input int hi);
    total_checks++;
    if (got < lo || got > hi) begin
      errors++;
      $display("unexpected at %0t: delay %h window %h %h", $time, got, lo,
               hi);
    end
  endtask

  task automatic apb_xfer(input logic wr, input logic [7:0] a,
                          input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdata = prdata;
    rd_err = pslverr;
    if (n >= 50)
      errors++;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge keeps two transfers from driving psel in one step
    @(posedge pclk);
  endtask

  task automatic do_reset(input logic presc, input logic spd);
    HOST.cfg(presc, spd);
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    check_val(result_ready_n, 1'b1);
    check_val(seq, '0);
    presetn <= 1'b1;
    @(posedge pclk);
    base = HOST.frame_cnt;
  endtask

  task automatic run_phase(input int k, input int gap, input logic spd);
    for (int i = 0; i < 6; i++) begin
      HOST.flip();
      repeat (gap) @(posedge pclk);
    end
    check_win(HOST.fall_cyc - HOST.tog_cyc, 1379 * k - 4,
              1380 * k + 12);
    check_val(HOST.frame_reg, {code_a, code_a, code_b, code_b,
              HOST.CHAIN});
    check_val(HOST.rdy_seen, 2'b01);
    apb_xfer(1'b0, STATUS_OFS, '0);
    check_val(rdata[ST_CONT_BIT], 1'b1);
    check_val({rdata[ST_PRESC_BIT], rdata[ST_SPEED_BIT]},
              {k == 4, spd});
    check_val(rdata[ST_SETTLED_BIT], HOST.frame_cnt - base >= 4);
    for (int j = 0; j < 4; j++) begin
      apb_xfer(1'b0, RESULT_OFS + 8'(4 * j), '0);
      check_val(rdata, {12'h000, j < 2 ? code_a : code_b});
    end
    $display("conversion phase with divider %0d done", k);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ********
  // Tests
  // ********
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    code_a = 20'hA5C3E;
    code_b = 20'h1F0B7;
    adc = {20'h1F0B7, 20'hA5C3E};
    @(posedge pclk);
    do_reset(1'b0, 1'b0);
    apb_xfer(1'b0, CTRL_OFS, '0);
    check_val(rdata, CTRL_RESET);
    apb_xfer(1'b0, 8'h40, '0);
    check_val({rd_err, rdata}, {1'b1, 32'h0000_0000});
    $display("register access test done");
    run_phase(1, 3000, 1'b0);
    // Second toggle lands while the measurement is still busy
    HOST.flip();
    repeat (1000) @(posedge pclk);
    HOST.flip();
    repeat (20) @(posedge pclk);
    check_val({seq.cont_mode, seq.inputs_grounded}, 2'b01);
    check_val({seq.integ_side_a, seq.meas_busy}, 2'b01);
    apb_xfer(1'b0, STATUS_OFS, '0);
    check_val(rdata[ST_CONT_BIT], 1'b0);
    $display("non-continuous test done");
    for (int n = 0; n < 12000 && result_ready_n !== 1'b0; n++)
      @(posedge pclk);
    // Let the host finish its frame so it is not counted after reset
    repeat (2) @(posedge pclk);
    wait (!HOST.busy);
    @(posedge pclk);
    code_a = 20'h0E24F;
    code_b = 20'h3C9D1;
    adc <= {20'h3C9D1, 20'h0E24F};
    do_reset(1'b1, 1'b1);
    HOST.flip();
    repeat (20) @(posedge pclk);
    HOST.flip();
    repeat (20) @(posedge pclk);
    apb_xfer(1'b0, STATUS_OFS, '0);
    check_val(rdata[ST_OVERRUN_BIT], 1'b1);
    apb_xfer(1'b1, STATUS_OFS, 32'h0000_0001 << ST_OVERRUN_BIT);
    apb_xfer(1'b0, STATUS_OFS, '0);
    check_val(rdata[ST_OVERRUN_BIT], 1'b0);
    $display("reset and overrun test done");
    run_phase(4, 7000, 1'b1);
    test_done();
  end

  initial begin
    repeat (95000) @(posedge pclk);
    errors++;
    $display("timeout: tests did not finish");
    test_done();
  end
endmodule
